// [common/flash_cmd_pkg.sv]
// shared constants and types for the serial flash id, security register and lock commands
//==========================================================================
// How it works
// - after 9Fh send maker byte, memory type, capacity, msb first on falling edges
// - 5Ah, 24-bit address, eight dummy clocks; table data starts at falling edge 40
// - table read upper sixteen address bits zero; low byte selects start byte
// - table read always takes a 24-bit address, even in four-byte mode
// - three 256-byte security registers, selected by a15-a12 = 1,2,3; a11-a8 zero
// - security register erase 44h accepted only while write enable latch is set
// - erase runs only if chip select rises exactly on a byte boundary after address
// - busy reads 1 during self-timed erase, status still readable, 0 when done
// - write enable latch clears when the erase cycle finishes
// - a set one-time lock bit makes erase of that register be ignored
// - 42h with latch set programs one to 256 bytes into erased locations
// - program aimed at a locked security register is ignored
// - 48h, address, eight dummy clocks; data bytes msb first on falling edges
// - read address increments per byte, wraps ffh to 00h within the register
// - security register read while busy is ignored, cycle undisturbed
// - erase, program, read and block lock use 32-bit address in four-byte mode
// - per-block locks protect only when select bit is 1, else range bits rule
// - per-block lock bits are volatile and reset to 1
// - 36h plus address, then chip select high, sets that block's lock bit
package flash_cmd_pkg;

  //==========================================================================
  // opcodes
  localparam logic [7:0] OP_READ_ID = 8'h9F;
  localparam logic [7:0] OP_PARAM_READ = 8'h5A;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SEC_PROG = 8'h42;
  localparam logic [7:0] OP_SEC_READ = 8'h48;
  localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;

  //==========================================================================
  // framing and address layout
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  localparam logic [2:0] ADDR_BYTES_SHORT = 3'h3;
  localparam logic [2:0] ADDR_BYTES_LONG = 3'h4;
  localparam logic [2:0] ADDR_LAST_LEFT = 3'h1;
  localparam int SECREG_COUNT = 3;
  localparam int SECREG_BYTES = 256;
  localparam int PARAM_BYTES = 256;
  localparam int ID_BYTES = 3;
  localparam int SEL_LSB = 12;
  localparam int PAD_LSB = 8;
  localparam int UPPER_LSB = 16;
  localparam logic [3:0] SEL_FIRST = 4'h1;
  localparam logic [3:0] SEL_LAST = 4'h3;
  localparam logic [3:0] PAD_ZERO = 4'h0;
  localparam logic [15:0] UPPER_ZERO = 16'h0000;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] ADDR_ZERO = 32'h0000_0000;

  //==========================================================================
  // timing
  localparam int CORE_CLK_MHZ = 20;
  localparam int ERASE_TIME_US = 1000;
  localparam int ERASE_CYCLES_DEFAULT = ERASE_TIME_US * CORE_CLK_MHZ;

  //==========================================================================
  // types
  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA_IN, ST_ARMED, ST_DATA_OUT, ST_IGNORE
  } cmd_state_t;

  typedef enum logic [1:0] {SRC_ID, SRC_PARAM, SRC_SECREG} out_src_t;

  typedef struct packed {
    logic protect_complement;
    logic protect_from_bottom;
    logic [3:0] protect_range_field;
  } protect_cfg_t;

  typedef struct packed {
    logic busy;
    logic write_enable_latch;
  } flash_status_t;

endpackage : flash_cmd_pkg

// [core/flash_id_secreg_lock_commands.sv]
// serial flash command logic: id, parameter table, security registers, block locks
`timescale 1ns/1ns
module flash_id_secreg_lock_commands #(
  parameter logic [7:0] MFR_ID = 8'hA5,      // arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h31,    // arbitrary value
  parameter logic [7:0] CAPACITY = 8'h42,    // arbitrary value
  parameter logic [2047:0] PARAM_TABLE = '0,
  parameter int NUM_BLOCKS = 512,
  parameter int BLOCK_ADDR_LSB = 16,
  parameter int BLK_W = $clog2(NUM_BLOCKS),
  parameter int ERASE_CYCLES = flash_cmd_pkg::ERASE_CYCLES_DEFAULT,
  parameter int BUF_DEPTH = 2,
  parameter int BUF_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // serial pins
  input wire logic chipSelN,
  input wire logic serialClk,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  // status and configuration
  input wire logic fourByteMode,
  input wire logic writeEnableSet,
  input wire logic [2:0] secregLockBits,
  input wire logic perBlockProtectSelect,
  input wire flash_cmd_pkg::protect_cfg_t protectCfg,
  output flash_cmd_pkg::flash_status_t status,
  // protection view
  input wire logic [BLK_W-1:0] lockQueryIdx,
  output logic lockQueryProtected,
  output logic rangeProtectActive,
  output flash_cmd_pkg::protect_cfg_t rangeProtectCfg
);
  import flash_cmd_pkg::*;

  localparam int ECNT_W = $clog2(ERASE_CYCLES + 1);
  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CNT_W = $clog2(BUF_DEPTH + 1);
  localparam logic [ECNT_W-1:0] ERASE_LOAD = ECNT_W'(ERASE_CYCLES);
  localparam logic [ECNT_W-1:0] ERASE_LAST = ECNT_W'(1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(BUF_DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(BUF_DEPTH);
  localparam logic [7:0] ID_LAST = 8'(ID_BYTES - 1);

  //==========================================================================
  // decode helpers
  function automatic logic secregValid(input logic [31:0] a);
    secregValid = (a[31:UPPER_LSB] == UPPER_ZERO) && (a[PAD_LSB +: 4] == PAD_ZERO) &&
                  (a[SEL_LSB +: 4] >= SEL_FIRST) && (a[SEL_LSB +: 4] <= SEL_LAST);
  endfunction : secregValid

  function automatic logic [1:0] secregIndex(input logic [31:0] a);
    secregIndex = 2'(a[SEL_LSB +: 4] - SEL_FIRST);
  endfunction : secregIndex

  //==========================================================================
  // pin synchronisers, stage 0 feeds stage 1 only
  logic [2:0] csSync_ff;
  logic [2:0] sclkSync_ff;
  logic [1:0] dinSync_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      csSync_ff <= 3'h7;
      sclkSync_ff <= 3'h0;
      dinSync_ff <= 2'h0;
    end else begin
      csSync_ff <= {csSync_ff[1:0], chipSelN};
      sclkSync_ff <= {sclkSync_ff[1:0], serialClk};
      dinSync_ff <= {dinSync_ff[0], serialIn};
    end
  end

  logic csLow;
  logic csRise;
  logic sclkRise;
  logic sclkFall;
  logic din;
  assign csLow = ~csSync_ff[1];
  assign csRise = csSync_ff[1] & ~csSync_ff[2];
  assign sclkRise = sclkSync_ff[1] & ~sclkSync_ff[2] & csLow;
  assign sclkFall = ~sclkSync_ff[1] & sclkSync_ff[2] & csLow;
  assign din = dinSync_ff[1];

  //==========================================================================
  // command decoder
  cmd_state_t state_ff;
  logic [7:0] opcode_ff;
  logic [7:0] inSr_ff;
  logic [2:0] bitIdx_ff;
  logic [2:0] addrLeft_ff;
  logic [31:0] addr_ff;
  logic progData_ff;
  logic busy_ff;
  logic wel_ff;
  logic [2:0] nxt_addrLeft;
  logic [7:0] rxByte;
  logic [31:0] nxtAddr;
  logic byteDone;
  logic progWrite;
  logic outStart;

  assign rxByte = {inSr_ff[6:0], din};
  assign nxtAddr = {addr_ff[23:0], rxByte};
  assign byteDone = sclkRise & (bitIdx_ff == LAST_BIT);
  assign progWrite = byteDone & (state_ff == ST_DATA_IN);
  assign nxt_addrLeft = (rxByte == OP_PARAM_READ || !fourByteMode) ?
                        ADDR_BYTES_SHORT : ADDR_BYTES_LONG;
  assign outStart = byteDone & ((state_ff == ST_DUMMY) ||
                    (state_ff == ST_OPCODE && rxByte == OP_READ_ID));

  always_ff @(posedge core_clk) begin
    if (sys_rst || csRise) begin
      bitIdx_ff <= FIRST_BIT;
      inSr_ff <= BYTE_ZERO;
    end else if (sclkRise) begin
      bitIdx_ff <= bitIdx_ff + 3'h1;
      inSr_ff <= rxByte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || csRise) begin
      state_ff <= ST_OPCODE;
    end else if (state_ff == ST_ARMED && sclkRise) begin
      state_ff <= ST_IGNORE;
    end else if (byteDone) begin
      case (state_ff)
        ST_OPCODE: begin
          case (rxByte)
            OP_READ_ID: state_ff <= ST_DATA_OUT;
            OP_PARAM_READ: state_ff <= ST_ADDR;
            OP_SEC_ERASE, OP_SEC_PROG: begin
              state_ff <= (wel_ff && !busy_ff) ? ST_ADDR : ST_IGNORE;
            end
            OP_SEC_READ: state_ff <= busy_ff ? ST_IGNORE : ST_ADDR;
            OP_BLOCK_LOCK: state_ff <= busy_ff ? ST_IGNORE : ST_ADDR;
            default: state_ff <= ST_IGNORE;
          endcase
        end
        ST_ADDR: begin
          if (addrLeft_ff == ADDR_LAST_LEFT) begin
            case (opcode_ff)
              OP_PARAM_READ: state_ff <= ST_DUMMY;
              OP_SEC_READ: state_ff <= secregValid(nxtAddr) ? ST_DUMMY : ST_IGNORE;
              OP_SEC_PROG: begin
                state_ff <= (secregValid(nxtAddr) &&
                             !secregLockBits[secregIndex(nxtAddr)]) ?
                            ST_DATA_IN : ST_IGNORE;
              end
              default: state_ff <= ST_ARMED;
            endcase
          end
        end
        ST_DUMMY: state_ff <= ST_DATA_OUT;
        default: state_ff <= state_ff;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      opcode_ff <= BYTE_ZERO;
      addrLeft_ff <= ADDR_BYTES_SHORT;
      addr_ff <= ADDR_ZERO;
    end else if (byteDone && state_ff == ST_OPCODE) begin
      opcode_ff <= rxByte;
      addrLeft_ff <= nxt_addrLeft;
      addr_ff <= ADDR_ZERO;
    end else if (byteDone && state_ff == ST_ADDR) begin
      addr_ff <= nxtAddr;
      addrLeft_ff <= addrLeft_ff - 3'h1;
    end else if (progWrite) begin
      addr_ff[7:0] <= addr_ff[7:0] + 8'h01;
    end
  end

  // program data lands only while chip select is held low
  always_ff @(posedge core_clk) begin
    if (sys_rst || csRise) begin
      progData_ff <= 1'b0;
    end else if (progWrite) begin
      progData_ff <= 1'b1;
    end
  end

  //==========================================================================
  // erase sequencing, block locks and write enable latch
  logic [ECNT_W-1:0] eraseCnt_ff;
  logic [1:0] eraseReg_ff;
  logic eraseStart;
  logic eraseDone;
  logic lockSet;
  logic progDone;
  logic [NUM_BLOCKS-1:0] blockLock_ff;

  assign eraseStart = csRise && state_ff == ST_ARMED && opcode_ff == OP_SEC_ERASE &&
                      secregValid(addr_ff) && !secregLockBits[secregIndex(addr_ff)];
  assign eraseDone = busy_ff && eraseCnt_ff == ERASE_LAST;
  assign lockSet = csRise && state_ff == ST_ARMED && opcode_ff == OP_BLOCK_LOCK;
  assign progDone = csRise && state_ff == ST_DATA_IN && progData_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_ff <= 1'b0;
      eraseCnt_ff <= '0;
      eraseReg_ff <= 2'h0;
    end else if (eraseStart) begin
      busy_ff <= 1'b1;
      eraseCnt_ff <= ERASE_LOAD;
      eraseReg_ff <= secregIndex(addr_ff);
    end else if (busy_ff) begin
      busy_ff <= !eraseDone;
      eraseCnt_ff <= eraseCnt_ff - ERASE_LAST;
    end
  end

  // set wins over the hardware clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wel_ff <= 1'b0;
    end else if (writeEnableSet) begin
      wel_ff <= 1'b1;
    end else if (eraseDone || progDone) begin
      wel_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      blockLock_ff <= '1;
    end else if (lockSet) begin
      blockLock_ff[addr_ff[BLOCK_ADDR_LSB +: BLK_W]] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lockQueryProtected <= 1'b1;
      rangeProtectActive <= 1'b0;
      rangeProtectCfg <= '0;
    end else begin
      lockQueryProtected <= perBlockProtectSelect & blockLock_ff[lockQueryIdx];
      rangeProtectActive <= ~perBlockProtectSelect;
      rangeProtectCfg <= perBlockProtectSelect ? '0 : protectCfg;
    end
  end

  assign status = '{busy: busy_ff, write_enable_latch: wel_ff};

  //==========================================================================
  // security register storage; erase sweeps one byte a cycle, so it needs 256+ cycles
  logic [7:0] secMem_ff [SECREG_COUNT][SECREG_BYTES];

  always_ff @(posedge core_clk) begin
    if (busy_ff) begin
      secMem_ff[eraseReg_ff][eraseCnt_ff[7:0]] <= ERASED_BYTE;
    end else if (progWrite) begin
      // programming only clears bits, as on erased cells
      secMem_ff[secregIndex(addr_ff)][addr_ff[7:0]] <=
        secMem_ff[secregIndex(addr_ff)][addr_ff[7:0]] & rxByte;
    end
  end

  //==========================================================================
  // read-ahead producer feeding the output buffer
  logic prodActive_ff;
  out_src_t prodSrc_ff;
  logic [7:0] prodPtr_ff;
  logic [1:0] prodReg_ff;
  logic [7:0] prodByte;
  logic bufInReady;
  logic push;

  always_comb begin
    case (prodSrc_ff)
      SRC_ID: prodByte = (prodPtr_ff == 8'h00) ? MFR_ID :
                         (prodPtr_ff == 8'h01) ? MEM_TYPE : CAPACITY;
      SRC_PARAM: prodByte = PARAM_TABLE[(PARAM_BYTES - 1 - int'(prodPtr_ff)) * 8 +: 8];
      SRC_SECREG: prodByte = secMem_ff[prodReg_ff][prodPtr_ff];
      default: prodByte = ERASED_BYTE;
    endcase
  end

  assign push = prodActive_ff & bufInReady;

  always_ff @(posedge core_clk) begin
    if (sys_rst || csRise) begin
      prodActive_ff <= 1'b0;
      prodSrc_ff <= SRC_ID;
      prodPtr_ff <= BYTE_ZERO;
      prodReg_ff <= 2'h0;
    end else if (outStart) begin
      prodActive_ff <= 1'b1;
      prodSrc_ff <= (state_ff == ST_OPCODE) ? SRC_ID :
                    (opcode_ff == OP_PARAM_READ) ? SRC_PARAM : SRC_SECREG;
      prodPtr_ff <= (state_ff == ST_DUMMY) ? addr_ff[7:0] : BYTE_ZERO;
      prodReg_ff <= secregIndex(addr_ff);
    end else if (push) begin
      if (prodSrc_ff == SRC_ID && prodPtr_ff == ID_LAST) begin
        prodPtr_ff <= BYTE_ZERO;
      end else begin
        prodPtr_ff <= prodPtr_ff + 8'h01;
      end
    end
  end

  //==========================================================================
  // two-entry buffer between producer and shifter; the shifter stalls the producer
  logic [BUF_W-1:0] bufMem_ff [BUF_DEPTH];
  logic [PTR_W-1:0] wrPtr_ff;
  logic [PTR_W-1:0] rdPtr_ff;
  logic [CNT_W-1:0] bufCnt_ff;
  logic bufOutValid;
  logic pop;

  assign bufInReady = (bufCnt_ff != CNT_FULL);
  assign bufOutValid = (bufCnt_ff != '0);

  always_ff @(posedge core_clk) begin
    if (sys_rst || csRise) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      bufCnt_ff <= '0;
    end else begin
      if (push) begin
        wrPtr_ff <= (wrPtr_ff == PTR_LAST) ? '0 : wrPtr_ff + PTR_W'(1);
      end
      if (pop) begin
        rdPtr_ff <= (rdPtr_ff == PTR_LAST) ? '0 : rdPtr_ff + PTR_W'(1);
      end
      bufCnt_ff <= bufCnt_ff + CNT_W'(push) - CNT_W'(pop);
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      bufMem_ff[wrPtr_ff] <= prodByte;
    end
  end

  //==========================================================================
  // output shifter, one bit per falling serial clock edge, msb first
  logic [2:0] outBit_ff;
  logic [7:0] outSr_ff;
  logic outDrive_ff;
  logic outData_ff;
  logic [7:0] headByte;
  logic shiftEdge;

  assign shiftEdge = sclkFall & (state_ff == ST_DATA_OUT);
  assign pop = shiftEdge & (outBit_ff == FIRST_BIT) & bufOutValid;
  // an underrun cannot happen at 400 ns serial clock; ones go out if it did
  assign headByte = bufOutValid ? bufMem_ff[rdPtr_ff] : ERASED_BYTE;

  always_ff @(posedge core_clk) begin
    if (sys_rst || csRise) begin
      outBit_ff <= FIRST_BIT;
      outSr_ff <= BYTE_ZERO;
      outData_ff <= 1'b0;
      outDrive_ff <= 1'b0;
    end else if (shiftEdge) begin
      outBit_ff <= outBit_ff + 3'h1;
      outDrive_ff <= 1'b1;
      if (outBit_ff == FIRST_BIT) begin
        outData_ff <= headByte[7];
        outSr_ff <= {headByte[6:0], 1'b0};
      end else begin
        outData_ff <= outSr_ff[7];
        outSr_ff <= {outSr_ff[6:0], 1'b0};
      end
    end
  end

  assign serialOut = outData_ff;
  assign serialOutEn = outDrive_ff & csLow;

endmodule : flash_id_secreg_lock_commands

// [sim/flash_cmd_sva.sv]
// port-level assertions for the flash command block
`timescale 1ns/1ns
module flash_cmd_sva #(
  parameter int ERASE_CYCLES = 300
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // serial pins
  input wire logic chipSelN,
  input wire logic serialClk,
  input wire logic serialOut,
  input wire logic serialOutEn,
  // status and protection
  input wire logic writeEnableSet,
  input wire logic perBlockProtectSelect,
  input wire flash_cmd_pkg::protect_cfg_t protectCfg,
  input wire flash_cmd_pkg::flash_status_t status,
  input wire logic lockQueryProtected,
  input wire logic rangeProtectActive,
  input wire flash_cmd_pkg::protect_cfg_t rangeProtectCfg
);
  import flash_cmd_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  //==========================================================================
  // busy length counter
  int busyCnt_ff;
  always_ff @(posedge core_clk) begin
    if (sys_rst || !status.busy) busyCnt_ff <= 0;
    else busyCnt_ff <= busyCnt_ff + 1;
  end
  //==========================================================================
  // assertions
  AST_BUSY_LEN: assert property ($fell(status.busy) |-> busyCnt_ff == ERASE_CYCLES)
    else $error("erase busy length wrong");
  AST_WEL_DONE: assert property (
    $fell(status.busy) && !$past(writeEnableSet) |-> !status.write_enable_latch)
    else $error("latch not cleared at erase end");
  AST_BUSY_WEL: assert property ($rose(status.busy) |-> $past(status.write_enable_latch))
    else $error("erase started without latch");
  AST_BUSY_CS: assert property (
    $rose(status.busy) |-> $past(chipSelN) && $past(chipSelN, 2))
    else $error("erase started inside a frame");
  // sync depth is two, four leaves a margin for the enable register
  AST_OE_CS: assert property (serialOutEn |-> !$past(chipSelN, 4))
    else $error("output driven after frame end");
  AST_OUT_HOLD: assert property (serialClk [*4] |-> $stable(serialOut))
    else $error("output moved while clock high");
  AST_RANGE_ACT: assert property (
    !$past(sys_rst) |-> rangeProtectActive == !$past(perBlockProtectSelect))
    else $error("range select wrong");
  AST_RANGE_CFG: assert property (
    !$past(sys_rst) |->
      rangeProtectCfg == ($past(perBlockProtectSelect) ? 6'h00 : $past(protectCfg)))
    else $error("range config wrong");
  AST_LOCK_SEL: assert property (
    !$past(sys_rst) && !$past(perBlockProtectSelect) |-> !lockQueryProtected)
    else $error("lock shown while deselected");
  AST_LOCK_RST: assert property (
    $past(sys_rst, 2) && !$past(sys_rst) && $past(perBlockProtectSelect)
      |-> lockQueryProtected)
    else $error("lock not set after reset");
  //==========================================================================
  // covers
  COV_ERASE: cover property ($fell(status.busy));
  COV_READ: cover property ($rose(serialOutEn));
  COV_DESEL: cover property ($fell(perBlockProtectSelect));
endmodule : flash_cmd_sva

bind flash_id_secreg_lock_commands flash_cmd_sva #(.ERASE_CYCLES(ERASE_CYCLES)) chk_u (
  .core_clk(core_clk), .sys_rst(sys_rst), .chipSelN(chipSelN), .serialClk(serialClk),
  .serialOut(serialOut), .serialOutEn(serialOutEn), .writeEnableSet(writeEnableSet),
  .perBlockProtectSelect(perBlockProtectSelect), .protectCfg(protectCfg),
  .status(status), .lockQueryProtected(lockQueryProtected),
  .rangeProtectActive(rangeProtectActive), .rangeProtectCfg(rangeProtectCfg));

// [sim/spi_host_model.sv]
// host serial controller model driving chip select, clock and data
`timescale 1ns/1ns
module spi_host_model (
  // clock
  input wire logic core_clk,
  // device side
  input wire logic serialOut,
  input wire logic serialOutEn,
  // host pins
  output logic chipSelN,
  output logic serialClk,
  output logic serialIn
);
  logic [7:0] txBuf [0:7];
  logic [7:0] rxBuf [0:7];
  logic oeSeen;
  initial begin
    chipSelN = 1'b1;
    serialClk = 1'b0;
    serialIn = 1'b0;
    oeSeen = 1'b0;
  end
  //==========================================================================
  // one half of a 400 ns serial clock
  task automatic halfBit();
    repeat (4) @(negedge core_clk);
  endtask : halfBit
  //==========================================================================
  // one frame: bytes out, bytes back, stray clocks before release
  task automatic frame(input int nTx, input int nRx, input int extra);
    int nBits;
    nBits = 8 * (nTx + nRx) + extra;
    oeSeen = 1'b0;
    @(negedge core_clk);
    chipSelN = 1'b0;
    halfBit();
    for (int k = 0; k < nBits; k++) begin
      serialClk = 1'b0;
      // released data toggles so a stale bit never reads as valid
      serialIn = (k < 8 * nTx) ? txBuf[k / 8][7 - k % 8] : ~serialIn;
      halfBit();
      serialClk = 1'b1;
      halfBit();
      if (k >= 8 * nTx) rxBuf[k / 8 - nTx][7 - k % 8] = serialOut;
      if (serialOutEn === 1'b1) oeSeen = 1'b1;
    end
    serialClk = 1'b0;
    halfBit();
    chipSelN = 1'b1;
    serialIn = ~serialIn;
    repeat (8) @(negedge core_clk);
  endtask : frame
endmodule : spi_host_model

// [sim/flash_id_secreg_lock_commands_tb.sv]
// self-checking bench for the flash command block
`timescale 1ns/1ns
module flash_id_secreg_lock_commands_tb;
  import flash_cmd_pkg::*;
  //==========================================================================
  // setup
  localparam logic [7:0] ID_A = 8'h6B; // arbitrary value
  localparam logic [7:0] ID_B = 8'h2E; // arbitrary value
  localparam logic [7:0] ID_C = 8'h19; // arbitrary value
  localparam int ERASE_N = 600; // longer than a read frame, so reads land inside busy
  function automatic logic [2047:0] mkTable();
    logic [2047:0] t;
    for (int i = 0; i < 256; i++) t[2047-8*i -: 8] = i[7:0];
    return t;
  endfunction : mkTable
  logic core_clk, sys_rst, fourByteMode, writeEnableSet, perBlockProtectSelect;
  logic chipSelN, serialClk, serialIn, serialOut, serialOutEn;
  logic lockQueryProtected, rangeProtectActive;
  logic [2:0] secregLockBits;
  logic [8:0] lockQueryIdx;
  protect_cfg_t protectCfg, rangeProtectCfg;
  flash_status_t status;
  logic [7:0] e [4];
  int errCount = 0;
  int testsRun = 0;
  flash_id_secreg_lock_commands #(.MFR_ID(ID_A), .MEM_TYPE(ID_B), .CAPACITY(ID_C),
    .PARAM_TABLE(mkTable()), .ERASE_CYCLES(ERASE_N)) dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .chipSelN(chipSelN), .serialClk(serialClk),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
    .fourByteMode(fourByteMode), .writeEnableSet(writeEnableSet),
    .secregLockBits(secregLockBits), .perBlockProtectSelect(perBlockProtectSelect),
    .protectCfg(protectCfg), .status(status), .lockQueryIdx(lockQueryIdx),
    .lockQueryProtected(lockQueryProtected), .rangeProtectActive(rangeProtectActive),
    .rangeProtectCfg(rangeProtectCfg));
  spi_host_model host_u (.core_clk(core_clk), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .chipSelN(chipSelN), .serialClk(serialClk),
    .serialIn(serialIn));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  //==========================================================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    if (errCount == 0 && testsRun > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic send(input logic [63:0] v, input int n, input int nRx, input int extra);
    for (int i = 0; i < n; i++) host_u.txBuf[i] = v[8*(n-1-i) +: 8];
    host_u.frame(n, nRx, extra);
  endtask : send
  task automatic setWel();
    @(negedge core_clk);
    writeEnableSet = 1'b1;
    @(negedge core_clk);
    writeEnableSet = 1'b0;
  endtask : setWel
  task automatic checkRx(input string what);
    for (int i = 0; i < 4; i++) check(what, host_u.rxBuf[i], e[i]);
  endtask : checkRx
  //==========================================================================
  // scenarios
  task automatic tLocks();
    check("lock after reset", lockQueryProtected, 1'h1);
    check("range off", rangeProtectActive, 1'h0);
    send({OP_BLOCK_LOCK, 24'h05_0000}, 4, 0, 0);
    check("lock kept", lockQueryProtected, 1'h1);
    perBlockProtectSelect = 1'b0;
    protectCfg = 6'h2B;
    repeat (2) @(negedge core_clk);
    check("lock masked", lockQueryProtected, 1'h0);
    check("range on", rangeProtectActive, 1'h1);
    check("range cfg", rangeProtectCfg, 6'h2B);
  endtask : tLocks
  task automatic tId();
    e = '{ID_A, ID_B, ID_C, ID_A};
    send(OP_READ_ID, 1, 4, 0);
    checkRx("id byte");
    check("id drive", host_u.oeSeen, 1'h1);
  endtask : tId
  task automatic tParam();
    fourByteMode = 1'b1;
    send({OP_PARAM_READ, 24'h00_00FD, 8'h00}, 5, 4, 0);
    fourByteMode = 1'b0;
    e = '{8'hFD, 8'hFE, 8'hFF, 8'h00};
    checkRx("table byte");
  endtask : tParam
  task automatic tRefused();
    send({OP_SEC_ERASE, 24'h00_1000}, 4, 0, 0);
    check("erase no latch", status.busy, 1'h0);
    setWel();
    send({OP_SEC_ERASE, 24'h00_1000}, 4, 0, 3);
    check("erase odd end", status.busy, 1'h0);
    secregLockBits = 3'h2;
    send({OP_SEC_ERASE, 24'h00_2000}, 4, 0, 0);
    check("erase locked", status.busy, 1'h0);
    send({OP_SEC_ERASE, 24'h00_1100}, 4, 0, 0);
    check("erase bad addr", status.busy, 1'h0);
    check("latch kept", status.write_enable_latch, 1'h1);
  endtask : tRefused
  task automatic tErase();
    send({OP_SEC_ERASE, 24'h00_1000}, 4, 0, 0);
    check("busy on", status.busy, 1'h1);
    send({OP_SEC_READ, 24'h00_1000, 8'h00}, 5, 1, 0);
    check("read while busy", host_u.oeSeen, 1'h0);
    check("busy kept", status.busy, 1'h1);
    for (int n = 0; n < 1000 && status.busy !== 1'b0; n++) @(negedge core_clk);
    check("busy done", status.busy, 1'h0);
    check("latch cleared", status.write_enable_latch, 1'h0);
  endtask : tErase
  task automatic tProg();
    setWel();
    send({OP_SEC_PROG, 24'h00_10FF, 16'h3C5A}, 6, 0, 0);
    check("latch after prog", status.write_enable_latch, 1'h0);
    send({OP_SEC_READ, 24'h00_10FE, 8'h00}, 5, 4, 0);
    e = '{8'hFF, 8'h3C, 8'h5A, 8'hFF};
    checkRx("secreg byte");
  endtask : tProg
  task automatic tLocked();
    secregLockBits = 3'h3;
    setWel();
    send({OP_SEC_PROG, 24'h00_1001, 8'h00}, 5, 0, 0);
    check("locked prog latch", status.write_enable_latch, 1'h1);
    fourByteMode = 1'b1;
    send({OP_SEC_READ, 32'h0000_1001, 8'h00}, 6, 1, 0);
    fourByteMode = 1'b0;
    check("locked prog data", host_u.rxBuf[0], 8'hFF);
  endtask : tLocked
  //==========================================================================
  // main sequence and watchdog
  initial begin
    sys_rst = 1'b1;
    fourByteMode = 1'b0;
    writeEnableSet = 1'b0;
    secregLockBits = 3'h0;
    perBlockProtectSelect = 1'b1;
    protectCfg = 6'h00;
    lockQueryIdx = 9'h005;
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge core_clk);
    tLocks();
    tId();
    tParam();
    tId();
    tRefused();
    tId();
    tErase();
    tProg();
    tLocked();
    summarize();
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    errCount++;
    summarize();
  end
endmodule : flash_id_secreg_lock_commands_tb
